//--- verilog/aervc_pkg.sv
// Package for the error-reporting and channel capability register bank.
// Assumes a 32-bit classic Wishbone slave; offsets are byte addresses.
package aervc_pkg;
	localparam logic [11:0] OFF_CE_STATUS = 12'h110;
	localparam logic [11:0] OFF_CE_MASK = 12'h114;
	localparam logic [11:0] OFF_CAPS_CTRL = 12'h118;
	localparam logic [11:0] OFF_HDR_LOG0 = 12'h11C;
	localparam logic [11:0] OFF_HDR_LOG1 = 12'h120;
	localparam logic [11:0] OFF_HDR_LOG2 = 12'h124;
	localparam logic [11:0] OFF_HDR_LOG3 = 12'h128;
	localparam logic [11:0] OFF_VC_HDR = 12'h140;
	localparam logic [11:0] OFF_VC_CAP1 = 12'h144;
	localparam logic [11:0] OFF_IRQ_STATUS = 12'h180;
	localparam logic [11:0] OFF_IRQ_CLEAR = 12'h184;
	localparam logic [11:0] OFF_IRQ_ENABLE = 12'h188;
	localparam logic [11:0] OFF_AUTOLOAD = 12'h18C;
	// Correctable event positions
	localparam logic [31:0] CE_IMPL_MASK = 32'h0000_31C1;
	localparam logic [31:0] CE_MASK_RESET = 32'h0000_2000;
	// Capabilities and control word fields
	localparam int FEP_LSB = 0;
	localparam int ECRC_GEN_CAP_BIT = 5;
	localparam int ECRC_GEN_EN_BIT = 6;
	localparam int ECRC_CHK_CAP_BIT = 7;
	localparam int ECRC_CHK_EN_BIT = 8;
	localparam logic [4:0] FEP_RESET = 5'h00;
	// Channel capability header
	localparam logic [15:0] VC_CAP_ID = 16'h0002;
	localparam logic [3:0] VC_CAP_VER = 4'h1;
	localparam logic [11:0] VC_NEXT_PTR = 12'h20C;
	// Port capability word 1 fields
	localparam int EVC_LSB = 0;
	localparam int LPEVC_LSB = 4;
	localparam int REFCLK_LSB = 8;
	localparam int ARB_ENT_LSB = 10;
	localparam logic [1:0] EVC_HI_RESET = 2'h0;
	localparam logic [2:0] LPEVC_RESET = 3'h0;
	localparam logic [1:0] REFCLK_100NS = 2'h0;
	localparam logic [1:0] ARB_ENT_4BIT = 2'h2;
	// Interrupt sources: bit0 correctable unmasked event, bit1 header captured
	localparam int IRQ_W = 2;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;
	localparam logic [31:0] BUS_ERR_DATA = 32'h0000_0000;
endpackage : aervc_pkg

//--- verilog/aervc_regs.sv
// Error-reporting and channel capability register bank of one switch port.
// Assumes a 32-bit classic Wishbone slave, synchronous events from the
// port logic on clk_i, and a strap pin from outside that is synchronised here.
`timescale 1ns/1ps
module aervc_regs
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cold_rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [31:0] ce_event_i,
	input wire logic uce_first_valid_i,
	input wire logic [4:0] uce_first_pos_i,
	input wire logic [127:0] hdr_i,
	input wire logic extra_channel_strap_i,
	input wire logic autoload_we_i,
	input wire logic [2:0] autoload_evc_i,
	input wire logic [2:0] autoload_lpevc_i,
	output logic [31:0] ce_msg_o,
	output logic ecrc_gen_en_o,
	output logic ecrc_chk_en_o,
	output logic irq_o
);
	localparam int IRQ_W_L = aervc_pkg::IRQ_W;
	// Sticky state uses cold_rst_i only; rst_i resets non-sticky state.
	logic [31:0] ce_mask_ff;
	logic [31:0] ce_status_ff;
	logic [4:0] fep_ff;
	logic gen_en_ff;
	logic chk_en_ff;
	logic [31:0] hdr_log_ff [0:3];
	logic hdr_valid_ff;
	logic [2:0] evc_ff;
	logic [2:0] lpevc_ff;
	logic strap_meta_ff;
	logic strap_sync_ff;
	logic strap_load_ff;
	logic [IRQ_W_L-1:0] irq_status_ff;
	logic [IRQ_W_L-1:0] irq_enable_ff;
	logic irq_ff;
	logic [31:0] ce_msg_ff;
	logic ack_ff;
	logic [31:0] dat_ff;
	logic [31:0] ce_hit;
	logic capture;
	logic wr_req;
	logic rd_req;
	logic [31:0] nxt_rdata;

	function automatic logic hit(input logic [11:0] adr, input logic [11:0] off);
		hit = (adr[11:2] == off[11:2]);
	endfunction : hit

	function automatic logic [31:0] bmask(input logic [3:0] sel);
		bmask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction : bmask

	assign wr_req = wb_cyc_i && wb_stb_i && wb_we_i && !ack_ff;
	assign rd_req = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_ff;
	// Unmasked events only reach reporting and capture
	assign ce_hit = ce_event_i & aervc_pkg::CE_IMPL_MASK & ~ce_mask_ff;
	assign capture = (|ce_hit) && !hdr_valid_ff;

	// Bus answer: one cycle after the request, every address acked
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_ff <= 1'b0;
		else
			ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
	end

	always_comb
	begin
		nxt_rdata = aervc_pkg::BUS_ERR_DATA;
		if (hit(wb_adr_i, aervc_pkg::OFF_CE_STATUS))
			nxt_rdata = ce_status_ff;
		else if (hit(wb_adr_i, aervc_pkg::OFF_CE_MASK))
			nxt_rdata = ce_mask_ff;
		else if (hit(wb_adr_i, aervc_pkg::OFF_CAPS_CTRL))
		begin
			nxt_rdata[aervc_pkg::FEP_LSB +: 5] = fep_ff;
			nxt_rdata[aervc_pkg::ECRC_GEN_CAP_BIT] = 1'b1;
			nxt_rdata[aervc_pkg::ECRC_GEN_EN_BIT] = gen_en_ff;
			nxt_rdata[aervc_pkg::ECRC_CHK_CAP_BIT] = 1'b1;
			nxt_rdata[aervc_pkg::ECRC_CHK_EN_BIT] = chk_en_ff;
		end
		else if (hit(wb_adr_i, aervc_pkg::OFF_HDR_LOG0))
			nxt_rdata = hdr_log_ff[0];
		else if (hit(wb_adr_i, aervc_pkg::OFF_HDR_LOG1))
			nxt_rdata = hdr_log_ff[1];
		else if (hit(wb_adr_i, aervc_pkg::OFF_HDR_LOG2))
			nxt_rdata = hdr_log_ff[2];
		else if (hit(wb_adr_i, aervc_pkg::OFF_HDR_LOG3))
			nxt_rdata = hdr_log_ff[3];
		else if (hit(wb_adr_i, aervc_pkg::OFF_VC_HDR))
			nxt_rdata = {aervc_pkg::VC_NEXT_PTR, aervc_pkg::VC_CAP_VER,
				aervc_pkg::VC_CAP_ID};
		else if (hit(wb_adr_i, aervc_pkg::OFF_VC_CAP1))
		begin
			nxt_rdata[aervc_pkg::EVC_LSB +: 3] = evc_ff;
			nxt_rdata[aervc_pkg::LPEVC_LSB +: 3] = lpevc_ff;
			nxt_rdata[aervc_pkg::REFCLK_LSB +: 2] = aervc_pkg::REFCLK_100NS;
			nxt_rdata[aervc_pkg::ARB_ENT_LSB +: 2] = aervc_pkg::ARB_ENT_4BIT;
		end
		else if (hit(wb_adr_i, aervc_pkg::OFF_IRQ_STATUS))
			nxt_rdata[IRQ_W_L-1:0] = irq_status_ff;
		else if (hit(wb_adr_i, aervc_pkg::OFF_IRQ_ENABLE))
			nxt_rdata[IRQ_W_L-1:0] = irq_enable_ff;
		// Unlisted offsets and reserved bits read zero
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dat_ff <= 32'h0000_0000;
		else if (rd_req)
			dat_ff <= nxt_rdata;
		else
			dat_ff <= 32'h0000_0000;
	end

	// Mask register, sticky
	always_ff @(posedge clk_i)
	begin
		if (cold_rst_i)
			ce_mask_ff <= aervc_pkg::CE_MASK_RESET;
		else if (wr_req && hit(wb_adr_i, aervc_pkg::OFF_CE_MASK))
			ce_mask_ff <= (ce_mask_ff & ~bmask(wb_sel_i)) |
				(wb_dat_i & bmask(wb_sel_i) & aervc_pkg::CE_IMPL_MASK);
	end

	// Status register: set wins over write-one-clear
	always_ff @(posedge clk_i)
	begin
		if (cold_rst_i)
			ce_status_ff <= 32'h0000_0000;
		else if (wr_req && hit(wb_adr_i, aervc_pkg::OFF_CE_STATUS))
			ce_status_ff <= (ce_status_ff & ~(wb_dat_i & bmask(wb_sel_i)))
				| (ce_event_i & aervc_pkg::CE_IMPL_MASK);
		else
			ce_status_ff <= ce_status_ff | (ce_event_i & aervc_pkg::CE_IMPL_MASK);
	end

	// Error messages towards the root complex, registered one cycle after each cycle of unmasked events
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ce_msg_ff <= 32'h0000_0000;
		else
			ce_msg_ff <= ce_hit;
	end

	// Control bits and first error pointer, sticky
	always_ff @(posedge clk_i)
	begin
		if (cold_rst_i)
		begin
			gen_en_ff <= 1'b0;
			chk_en_ff <= 1'b0;
		end
		else if (wr_req && hit(wb_adr_i, aervc_pkg::OFF_CAPS_CTRL) && wb_sel_i[0])
			gen_en_ff <= wb_dat_i[aervc_pkg::ECRC_GEN_EN_BIT];
		if (!cold_rst_i && wr_req && hit(wb_adr_i, aervc_pkg::OFF_CAPS_CTRL) && wb_sel_i[1])
			chk_en_ff <= wb_dat_i[aervc_pkg::ECRC_CHK_EN_BIT];
	end

	always_ff @(posedge clk_i)
	begin
		if (cold_rst_i)
			fep_ff <= aervc_pkg::FEP_RESET;
		else if (uce_first_valid_i)
			fep_ff <= uce_first_pos_i;
	end

	// Header log: first unmasked event captures, held until cold reset
	always_ff @(posedge clk_i)
	begin
		if (cold_rst_i)
			hdr_valid_ff <= 1'b0;
		else if (capture)
			hdr_valid_ff <= 1'b1;
	end

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_hdr
			always_ff @(posedge clk_i)
			begin
				if (cold_rst_i)
					hdr_log_ff[gi] <= 32'h0000_0000;
				else if (capture)
					hdr_log_ff[gi] <= hdr_i[127-32*gi -: 32];
			end
		end
	endgenerate

	// Strap synchroniser and channel counts
	always_ff @(posedge clk_i)
	begin
		strap_meta_ff <= extra_channel_strap_i;
		strap_sync_ff <= strap_meta_ff;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			strap_load_ff <= 1'b1;
		else
			strap_load_ff <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			evc_ff <= 3'h0;
			lpevc_ff <= aervc_pkg::LPEVC_RESET;
		end
		else if (autoload_we_i)
		begin
			evc_ff <= autoload_evc_i;
			lpevc_ff <= autoload_lpevc_i;
		end
		else if (strap_load_ff)
			evc_ff <= {aervc_pkg::EVC_HI_RESET, strap_sync_ff};
	end

	// Interrupt status, enable, clear
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_status_ff <= aervc_pkg::IRQ_RESET;
		else if (wr_req && hit(wb_adr_i, aervc_pkg::OFF_IRQ_CLEAR) && wb_sel_i[0])
			irq_status_ff <= (irq_status_ff & ~wb_dat_i[IRQ_W_L-1:0]) | {capture, |ce_hit};
		else
			irq_status_ff <= irq_status_ff | {capture, |ce_hit};
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_enable_ff <= aervc_pkg::IRQ_RESET;
		else if (wr_req && hit(wb_adr_i, aervc_pkg::OFF_IRQ_ENABLE) && wb_sel_i[0])
			irq_enable_ff <= wb_dat_i[IRQ_W_L-1:0];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_ff <= 1'b0;
		else
			irq_ff <= |(irq_status_ff & irq_enable_ff);
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = dat_ff;
	assign ce_msg_o = ce_msg_ff;
	assign ecrc_gen_en_o = gen_en_ff;
	assign ecrc_chk_en_o = chk_en_ff;
	assign irq_o = irq_ff;

	property p_mask_blocks_msg;
		@(posedge clk_i) disable iff (rst_i)
		(ce_event_i[0] && ce_mask_ff[0]) |=> !ce_msg_o[0];
	endproperty
	a_mask_blocks_msg: assert property (p_mask_blocks_msg) else $error("masked event reported");

	property p_unmasked_msg;
		@(posedge clk_i) disable iff (rst_i)
		(ce_event_i[6] && !ce_mask_ff[6]) |=> ce_msg_o[6];
	endproperty
	a_unmasked_msg: assert property (p_unmasked_msg) else $error("unmasked event lost");

	property p_mask_reset;
		@(posedge clk_i) $past(cold_rst_i) |-> (ce_mask_ff == aervc_pkg::CE_MASK_RESET);
	endproperty
	a_mask_reset: assert property (p_mask_reset) else $error("mask reset value wrong");

	property p_status_set;
		@(posedge clk_i) disable iff (cold_rst_i)
		ce_event_i[13] |=> ce_status_ff[13];
	endproperty
	a_status_set: assert property (p_status_set) else $error("status not set");

	property p_sticky_hold;
		@(posedge clk_i) (rst_i && !cold_rst_i && !wr_req) |=> $stable(ce_mask_ff);
	endproperty
	a_sticky_hold: assert property (p_sticky_hold) else $error("sticky mask lost");

	property p_hdr_hold;
		@(posedge clk_i) disable iff (cold_rst_i)
		hdr_valid_ff |=> $stable(hdr_log_ff[0]);
	endproperty
	a_hdr_hold: assert property (p_hdr_hold) else $error("header log overwritten");

	property p_ack_once;
		@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");

	property p_fep;
		@(posedge clk_i) disable iff (cold_rst_i)
		uce_first_valid_i |=> (fep_ff == $past(uce_first_pos_i));
	endproperty
	a_fep: assert property (p_fep) else $error("pointer not updated");

	property p_ctrl_cold;
		@(posedge clk_i)
		$past(cold_rst_i) |-> (!gen_en_ff && !chk_en_ff && fep_ff == aervc_pkg::FEP_RESET);
	endproperty
	a_ctrl_cold: assert property (p_ctrl_cold) else $error("control reset wrong");

	property p_caps_fixed;
		@(posedge clk_i) disable iff (rst_i)
		(rd_req && hit(wb_adr_i, aervc_pkg::OFF_CAPS_CTRL)) |=> (wb_dat_o[aervc_pkg::ECRC_GEN_CAP_BIT]
			&& wb_dat_o[aervc_pkg::ECRC_CHK_CAP_BIT] && wb_dat_o[31:9] == 23'h0);
	endproperty
	a_caps_fixed: assert property (p_caps_fixed) else $error("caps bits wrong");

	property p_vc_hdr_fixed;
		@(posedge clk_i) disable iff (rst_i)
		(rd_req && hit(wb_adr_i, aervc_pkg::OFF_VC_HDR)) |=> (wb_dat_o == {aervc_pkg::VC_NEXT_PTR,
			aervc_pkg::VC_CAP_VER, aervc_pkg::VC_CAP_ID});
	endproperty
	a_vc_hdr_fixed: assert property (p_vc_hdr_fixed) else $error("vc header wrong");

	property p_cap1_fixed;
		@(posedge clk_i) disable iff (rst_i)
		(rd_req && hit(wb_adr_i, aervc_pkg::OFF_VC_CAP1)) |=> (wb_dat_o[31:12] == 20'h0
			&& wb_dat_o[11:8] == {aervc_pkg::ARB_ENT_4BIT, aervc_pkg::REFCLK_100NS}
			&& !wb_dat_o[3] && !wb_dat_o[7]);
	endproperty
	a_cap1_fixed: assert property (p_cap1_fixed) else $error("cap1 fixed bits wrong");

	property p_strap_load;
		@(posedge clk_i)
		(strap_load_ff && !rst_i && !autoload_we_i) |=>
			(evc_ff == {aervc_pkg::EVC_HI_RESET, $past(strap_sync_ff)});
	endproperty
	a_strap_load: assert property (p_strap_load) else $error("strap count not loaded");

	property p_masked_no_capture;
		@(posedge clk_i) disable iff (cold_rst_i)
		(!hdr_valid_ff && !(|(ce_event_i & aervc_pkg::CE_IMPL_MASK & ~ce_mask_ff))) |=> !hdr_valid_ff;
	endproperty
	a_masked_no_capture: assert property (p_masked_no_capture) else $error("masked capture");
endmodule : aervc_regs

//--- tb/aervc_rc_model.sv
// Root complex model: issues single configuration accesses as a Wishbone master.
// Assumes the register bank answers each request with a one-cycle ack.
`timescale 1ns/1ps
module aervc_rc_model
(
	input wire logic clk_i,
	input wire logic wb_ack_i,
	input wire logic [31:0] wb_dat_i,
	output logic wb_cyc_o,
	output logic wb_stb_o,
	output logic wb_we_o,
	output logic [11:0] wb_adr_o,
	output logic [3:0] wb_sel_o,
	output logic [31:0] wb_dat_o,
	output logic timeout_o
);
	initial
	begin
		wb_cyc_o = 1'b0;
		wb_stb_o = 1'b0;
		wb_we_o = 1'b0;
		wb_adr_o = 12'h000;
		wb_sel_o = 4'h0;
		wb_dat_o = 32'h0;
		timeout_o = 1'b0;
	end
	task automatic access(input logic we, input logic [11:0] adr, input logic [31:0] wdat,
		output logic [31:0] rdat);
		int n;
		@(posedge clk_i);
		wb_cyc_o <= 1'b1;
		wb_stb_o <= 1'b1;
		wb_we_o <= we;
		wb_adr_o <= adr;
		wb_sel_o <= 4'hF;
		wb_dat_o <= wdat;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (wb_ack_i !== 1'b1 && n < 50);
		rdat = wb_dat_i;
		timeout_o <= (n >= 50);
		wb_cyc_o <= 1'b0;
		wb_stb_o <= 1'b0;
		// Idle bus carries changed values, never the last ones
		wb_we_o <= ~we;
		wb_adr_o <= ~adr;
		wb_sel_o <= 4'h0;
		wb_dat_o <= ~wdat;
		@(posedge clk_i);
		#1;
	endtask : access
endmodule : aervc_rc_model

//--- tb/tb_top.sv
// Self-checking bench for the capability register bank.
// Assumes the root complex model as bus master and a single 100 MHz clock.
`timescale 1ns/1ps
module tb_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cold_rst_i = 1'b1;
	logic [31:0] ce_event_i = 32'h0;
	logic uce_first_valid_i = 1'b0;
	logic [4:0] uce_first_pos_i = 5'h00;
	logic [127:0] hdr_i = 128'h0;
	logic autoload_we_i = 1'b0;
	logic [2:0] autoload_evc_i = 3'h0;
	logic [2:0] autoload_lpevc_i = 3'h0;
	logic extra_channel_strap = 1'b1;
	logic cyc, stb, we, ack, tmo, gen_en, chk_en, irq;
	logic [11:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, ce_msg, m, e;
	int bad_count = 0;
	int samples_checked = 0;
	aervc_rc_model rc (.clk_i(clk_i), .wb_ack_i(ack), .wb_dat_i(rdat), .wb_cyc_o(cyc),
		.wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat),
		.timeout_o(tmo));
	aervc_regs dut (.clk_i(clk_i), .rst_i(rst_i), .cold_rst_i(cold_rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .ce_event_i(ce_event_i),
		.uce_first_valid_i(uce_first_valid_i), .uce_first_pos_i(uce_first_pos_i),
		.hdr_i(hdr_i), .extra_channel_strap_i(extra_channel_strap),
		.autoload_we_i(autoload_we_i),
		.autoload_evc_i(autoload_evc_i), .autoload_lpevc_i(autoload_lpevc_i),
		.ce_msg_o(ce_msg), .ecrc_gen_en_o(gen_en), .ecrc_chk_en_o(chk_en), .irq_o(irq));
	initial
	begin
		forever #5 clk_i = ~clk_i;
	end
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	// Unmasked implemented events are the ones reported
	function automatic logic [31:0] exp_msg(input logic [31:0] ev_v, input logic [31:0] mask_v);
		exp_msg = ev_v & aervc_pkg::CE_IMPL_MASK & ~mask_v;
	endfunction : exp_msg
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		rc.access(w, a, d, q);
		if (tmo !== 1'b0)
		begin
			bad_count++;
			$display("CHECK FAILED t=%0t no ack", $time);
			report_and_stop();
		end
	endtask : bus
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, exp, what);
	endtask : rd_chk
	task automatic ev(input logic [31:0] v);
		@(posedge clk_i);
		ce_event_i <= v;
		@(posedge clk_i);
		ce_event_i <= 32'h0;
		#1;
	endtask : ev
	task automatic do_reset(input logic cold);
		@(posedge clk_i);
		rst_i <= 1'b1;
		cold_rst_i <= cold;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		cold_rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask : do_reset
	initial
	begin
		m = $urandom(32'hC3A64F0B);
		do_reset(1'b1);
		hdr_i <= {$urandom, $urandom, $urandom, $urandom};
		ev(32'h0000_0001);
		chk(ce_msg, 32'h0000_0001, "msg");
		for (int k = 0; k < 4; k++)
			rd_chk(aervc_pkg::OFF_HDR_LOG0 + 12'(4 * k), hdr_i[127 - 32 * k -: 32], "hdr");
		rd_chk(aervc_pkg::OFF_CE_STATUS, 32'h0000_0001, "sts");
		wr(aervc_pkg::OFF_CE_STATUS, 32'h0000_0001);
		rd_chk(aervc_pkg::OFF_CE_STATUS, 32'h0, "sts clr");
		$display("test capture done");
		rd_chk(aervc_pkg::OFF_CE_MASK, 32'h0000_2000, "mask");
		rd_chk(aervc_pkg::OFF_CAPS_CTRL, 32'h0000_00A0, "caps");
		rd_chk(aervc_pkg::OFF_VC_HDR, 32'h20C1_0002, "vc hdr");
		rd_chk(aervc_pkg::OFF_VC_CAP1, 32'h0000_0801, "cap1");
		rd_chk(aervc_pkg::OFF_AUTOLOAD, 32'h0, "rsvd");
		$display("test defaults done");
		wr(aervc_pkg::OFF_CE_MASK, 32'hFFFF_FFFF);
		rd_chk(aervc_pkg::OFF_CE_MASK, 32'h0000_31C1, "mask wr");
		wr(aervc_pkg::OFF_CAPS_CTRL, 32'hFFFF_FFFF);
		rd_chk(aervc_pkg::OFF_CAPS_CTRL, 32'h0000_01E0, "caps wr");
		wr(aervc_pkg::OFF_VC_CAP1, 32'h0);
		wr(aervc_pkg::OFF_VC_HDR, 32'h0);
		rd_chk(aervc_pkg::OFF_VC_CAP1, 32'h0000_0801, "cap1 ro");
		rd_chk(aervc_pkg::OFF_VC_HDR, 32'h20C1_0002, "hdr ro");
		ev(32'h0000_31C1);
		chk(ce_msg, 32'h0, "masked");
		do_reset(1'b0);
		rd_chk(aervc_pkg::OFF_CE_MASK, 32'h0000_31C1, "mask warm");
		rd_chk(aervc_pkg::OFF_CAPS_CTRL, 32'h0000_01E0, "caps warm");
		chk({30'h0, gen_en, chk_en}, 32'h3, "ecrc en");
		$display("test sticky done");
		@(posedge clk_i);
		uce_first_valid_i <= 1'b1;
		uce_first_pos_i <= 5'h15;
		autoload_we_i <= 1'b1;
		autoload_evc_i <= 3'h5;
		autoload_lpevc_i <= 3'h3;
		@(posedge clk_i);
		uce_first_valid_i <= 1'b0;
		autoload_we_i <= 1'b0;
		rd_chk(aervc_pkg::OFF_CAPS_CTRL, 32'h0000_01F5, "pointer");
		rd_chk(aervc_pkg::OFF_VC_CAP1, 32'h0000_0835, "autoload");
		$display("test load done");
		@(posedge clk_i);
		extra_channel_strap <= 1'b0;
		do_reset(1'b0);
		rd_chk(aervc_pkg::OFF_VC_CAP1, 32'h0000_0800, "strap low");
		rd_chk(aervc_pkg::OFF_CAPS_CTRL, 32'h0000_01F5, "pointer warm");
		$display("test strap done");
		for (int i = 0; i < 8; i++)
		begin
			m = $urandom & 32'h0000_31C1;
			wr(aervc_pkg::OFF_CE_MASK, m);
			e = $urandom;
			ev(e);
			chk(ce_msg, exp_msg(e, m), "msg rnd");
		end
		$display("test random done");
		wr(aervc_pkg::OFF_IRQ_CLEAR, 32'h3);
		wr(aervc_pkg::OFF_CE_MASK, 32'h0);
		wr(aervc_pkg::OFF_IRQ_ENABLE, 32'h1);
		chk({31'h0, irq}, 32'h0, "irq idle");
		ev(32'h0000_0040);
		@(posedge clk_i);
		#1;
		chk({31'h0, irq}, 32'h1, "irq set");
		wr(aervc_pkg::OFF_IRQ_ENABLE, 32'h0);
		chk({31'h0, irq}, 32'h0, "irq off");
		wr(aervc_pkg::OFF_IRQ_ENABLE, 32'h1);
		chk({31'h0, irq}, 32'h1, "irq on");
		wr(aervc_pkg::OFF_IRQ_CLEAR, 32'h1);
		chk({31'h0, irq}, 32'h0, "irq clr");
		$display("test irq done");
		do_reset(1'b1);
		hdr_i <= {$urandom, $urandom, $urandom, $urandom};
		rd_chk(aervc_pkg::OFF_CE_MASK, 32'h0000_2000, "mask cold");
		rd_chk(aervc_pkg::OFF_CAPS_CTRL, 32'h0000_00A0, "caps cold");
		rd_chk(aervc_pkg::OFF_CE_STATUS, 32'h0, "sts cold");
		ev(32'h0000_2000);
		chk(ce_msg, exp_msg(32'h0000_2000, 32'h0000_2000), "adv masked");
		rd_chk(aervc_pkg::OFF_HDR_LOG0, 32'h0, "no capture");
		ev(32'h0000_0100);
		chk(ce_msg, 32'h0000_0100, "msg cold");
		rd_chk(aervc_pkg::OFF_HDR_LOG3, hdr_i[31:0], "hdr cold");
		rd_chk(aervc_pkg::OFF_IRQ_STATUS, 32'h3, "irq sts");
		$display("test cold done");
		report_and_stop();
	end
endmodule : tb_top
